// file: bat_bus_model.sv
// partner model: local bus attributes and data comparator hits.
// assumes the caller steps it just after a rising clock edge.
`timescale 1ns/1ps

// ==========================================================
// local bus side
module bat_bus_model (
    output bat_pkg::bat_bus_s bus,
    output logic [6:0] hits
);
    initial begin
        bus = '0;
        hits = 7'h00;
    end

    // idle bus shows flipped attributes, never the last ones
    task automatic drive(input logic v, input logic [7:0] a,
                         input logic [6:0] h);
        if (v) begin
            bus <= {1'b1, a, 2'h0};
        end else begin
            bus <= {1'b0, ~bus[9:2], ~bus[1:0]};
        end
        hits <= h;
    endtask
endmodule

// file: bat_pkg.sv
// package for the breakpoint attribute/trigger block: register numbers,
// field positions, reset values, encodings and carrier structs.
// assumes a single processor clock domain; no other files needed.
package bat_pkg;

    // ==========================================================
    // debug control register numbers
    localparam logic [3:0] REG_ATTR = 4'h6;
    localparam logic [3:0] REG_TDEF = 4'h7;

    // ==========================================================
    // attribute_trigger field positions
    localparam int ATTR_DIR_MASK = 15;
    localparam int ATTR_SIZE_MASK_HI = 14;
    localparam int ATTR_SIZE_MASK_LO = 13;
    localparam int ATTR_TT_MASK_HI = 12;
    localparam int ATTR_TT_MASK_LO = 11;
    localparam int ATTR_TM_MASK_HI = 10;
    localparam int ATTR_TM_MASK_LO = 8;
    localparam int ATTR_DIR = 7;
    localparam int ATTR_SIZE_HI = 6;
    localparam int ATTR_SIZE_LO = 5;
    localparam int ATTR_TT_HI = 4;
    localparam int ATTR_TT_LO = 3;
    localparam int ATTR_TM_HI = 2;
    localparam int ATTR_TM_LO = 0;
    // implemented bits; 31..16 are reserved and held at zero
    localparam logic [31:0] ATTR_WMASK = 32'h0000_ffff;
    localparam logic [31:0] ATTR_RESET = 32'h0000_0005;

    // ==========================================================
    // trigger_definition field positions: upper half, plus the level one enable at bit 13
    localparam int TDEF_RESP_HI = 31;
    localparam int TDEF_RESP_LO = 30;
    localparam int TDEF_L2_EN = 29;
    localparam int TDEF_LANE_HI = 28;
    localparam int TDEF_LANE_LO = 22;
    localparam int TDEF_L1_EN = 13;
    localparam logic [31:0] TDEF_RESET = 32'h0000_0000;

    // lane enable indices within the 7-bit field
    localparam int LANE_LONG = 6;
    localparam int LANE_LWORD = 5;
    localparam int LANE_UWORD = 4;
    localparam int LANE_B0 = 3;
    localparam int LANE_B1 = 2;
    localparam int LANE_B2 = 1;
    localparam int LANE_B3 = 0;

    // ==========================================================
    // encodings
    localparam logic [1:0] SIZE_LONG = 2'h0;
    localparam logic [1:0] SIZE_BYTE = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam logic [1:0] RESP_SHOW = 2'h0;
    localparam logic [1:0] RESP_HALT = 2'h1;
    localparam logic [1:0] RESP_IRQ = 2'h2;

    typedef enum logic [1:0] {
        BAT_LVL_OFF,
        BAT_LVL_ONE,
        BAT_LVL_TWO
    } bat_level_e;

    // one local-bus attribute sample
    typedef struct packed {
        logic valid;
        logic dir;
        logic [1:0] size;
        logic [1:0] ttype;
        logic [2:0] tmod;
        logic [1:0] addr_lo;
    } bat_bus_s;

    // register write port, shared by instruction and debug port
    typedef struct packed {
        logic wr;
        logic [3:0] regno;
        logic [31:0] data;
    } bat_wr_s;

endpackage

// file: bat_trigger.sv
// breakpoint attribute match and upper trigger definition.
// assumes one write source per cycle from each of the instruction and
// debug port paths; both come in on the processor clock.
`timescale 1ns/1ps

module bat_trigger (
    input wire logic clk,
    input wire logic rstn,
    input bat_pkg::bat_wr_s instr_wr,
    input bat_pkg::bat_wr_s port_wr,
    input bat_pkg::bat_bus_s bus,
    input wire logic addr_hit,
    input wire logic data_hit_long,
    input wire logic data_hit_lword,
    input wire logic data_hit_uword,
    input wire logic [3:0] data_hit_byte,
    output logic attr_match,
    output logic data_match,
    output logic level2_fire,
    output logic show_status,
    output logic halt_req,
    output logic debug_irq,
    output logic status_clear,
    output logic [1:0] port_ttype,
    output logic [2:0] port_tmod,
    output logic level1_enable,
    output bat_pkg::bat_level_e level_mode
);

    // ==========================================================
    // register write decode
    // the port write wins if both arrive together; software can not
    // reach these registers while the core is halted anyway
    wire bat_pkg::bat_wr_s wsel = port_wr.wr ? port_wr : instr_wr;
    wire attr_we = wsel.wr && (wsel.regno == bat_pkg::REG_ATTR);
    wire tdef_we = wsel.wr && (wsel.regno == bat_pkg::REG_TDEF);

    logic [31:0] attr_q;
    logic [31:0] attr_d;
    logic [31:0] tdef_q;
    logic [31:0] tdef_d;

    assign attr_d = attr_we ? (wsel.data & bat_pkg::ATTR_WMASK) : attr_q;
    assign tdef_d = tdef_we ? wsel.data : tdef_q;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            attr_q <= bat_pkg::ATTR_RESET;
            tdef_q <= bat_pkg::TDEF_RESET;
        end else begin
            attr_q <= attr_d;
            tdef_q <= tdef_d;
        end
    end

    // ==========================================================
    // attribute compare
    function automatic logic masked_eq(input logic [2:0] a,
                                       input logic [2:0] b,
                                       input logic [2:0] m);
        masked_eq = &(~(a ^ b) | m);
    endfunction

    wire dir_ok = masked_eq({2'h0, attr_q[bat_pkg::ATTR_DIR]},
        {2'h0, bus.dir}, {2'h0, attr_q[bat_pkg::ATTR_DIR_MASK]});
    wire size_ok = masked_eq(
        {1'b0, attr_q[bat_pkg::ATTR_SIZE_HI:bat_pkg::ATTR_SIZE_LO]},
        {1'b0, bus.size},
        {1'b0, attr_q[bat_pkg::ATTR_SIZE_MASK_HI:
                      bat_pkg::ATTR_SIZE_MASK_LO]});
    wire tt_ok = masked_eq(
        {1'b0, attr_q[bat_pkg::ATTR_TT_HI:bat_pkg::ATTR_TT_LO]},
        {1'b0, bus.ttype},
        {1'b0, attr_q[bat_pkg::ATTR_TT_MASK_HI:
                      bat_pkg::ATTR_TT_MASK_LO]});
    wire tm_ok = masked_eq(
        attr_q[bat_pkg::ATTR_TM_HI:bat_pkg::ATTR_TM_LO],
        bus.tmod,
        attr_q[bat_pkg::ATTR_TM_MASK_HI:bat_pkg::ATTR_TM_MASK_LO]);
    wire attr_ok = bus.valid && dir_ok && size_ok && tt_ok && tm_ok;

    // ==========================================================
    // data lane selection
    wire [6:0] lane_en = tdef_q[bat_pkg::TDEF_LANE_HI:bat_pkg::TDEF_LANE_LO];
    wire [6:0] lane_hit = {data_hit_long, data_hit_lword, data_hit_uword,
                           data_hit_byte[0], data_hit_byte[1],
                           data_hit_byte[2], data_hit_byte[3]};
    wire lanes_on = |lane_en;
    // all lanes clear means no data term, so the address and attribute terms stand alone
    wire data_ok = lanes_on ? |(lane_en & lane_hit) : 1'b1;

    // ==========================================================
    // level two trigger and response
    wire l2_on = tdef_q[bat_pkg::TDEF_L2_EN];
    wire l1_on = tdef_q[bat_pkg::TDEF_L1_EN];
    wire [1:0] resp = tdef_q[bat_pkg::TDEF_RESP_HI:bat_pkg::TDEF_RESP_LO];
    wire fire = l2_on && addr_hit && attr_ok && data_ok;

    wire bat_pkg::bat_level_e mode_d = !l2_on ? bat_pkg::BAT_LVL_OFF :
        (l1_on ? bat_pkg::BAT_LVL_TWO : bat_pkg::BAT_LVL_ONE);

    // port fields leave reset in step with the register default
    wire [1:0] ttype_rst =
        bat_pkg::ATTR_RESET[bat_pkg::ATTR_TT_HI:bat_pkg::ATTR_TT_LO];
    wire [2:0] tmod_rst =
        bat_pkg::ATTR_RESET[bat_pkg::ATTR_TM_HI:bat_pkg::ATTR_TM_LO];

    always_ff @(posedge clk) begin
        if (!rstn) begin
            attr_match <= 1'b0;
            data_match <= 1'b0;
            level2_fire <= 1'b0;
            show_status <= 1'b0;
            halt_req <= 1'b0;
            debug_irq <= 1'b0;
            status_clear <= 1'b0;
            port_ttype <= ttype_rst;
            port_tmod <= tmod_rst;
            level1_enable <= 1'b0;
            level_mode <= bat_pkg::BAT_LVL_OFF;
        end else begin
            attr_match <= attr_ok;
            data_match <= lanes_on && data_ok;
            level2_fire <= fire;
            // reserved response 11 does nothing beyond showing status
            show_status <= fire;
            halt_req <= fire && (resp == bat_pkg::RESP_HALT);
            debug_irq <= fire && (resp == bat_pkg::RESP_IRQ);
            status_clear <= tdef_we;
            port_ttype <= attr_d[bat_pkg::ATTR_TT_HI:bat_pkg::ATTR_TT_LO];
            port_tmod <= attr_d[bat_pkg::ATTR_TM_HI:bat_pkg::ATTR_TM_LO];
            level1_enable <= tdef_d[bat_pkg::TDEF_L1_EN];
            level_mode <= mode_d;
        end
    end

    // ==========================================================
    // checks
    property p_clear_on_write;
        @(posedge clk) disable iff (!rstn)
        tdef_we |=> status_clear;
    endproperty
    a_clear_on_write: assert property (p_clear_on_write)
        else $error("status not cleared after definition write");

    property p_halt_resp;
        @(posedge clk) disable iff (!rstn)
        halt_req |-> level2_fire && $past(resp) == bat_pkg::RESP_HALT;
    endproperty
    a_halt_resp: assert property (p_halt_resp)
        else $error("halt without matching response");

    property p_irq_resp;
        @(posedge clk) disable iff (!rstn)
        (fire && resp == bat_pkg::RESP_IRQ) |=> debug_irq && !halt_req;
    endproperty
    a_irq_resp: assert property (p_irq_resp)
        else $error("debug interrupt missing");

    property p_l2_off;
        @(posedge clk) disable iff (!rstn)
        !l2_on |=> !level2_fire;
    endproperty
    a_l2_off: assert property (p_l2_off)
        else $error("fire while level two disabled");

    property p_attr_write;
        @(posedge clk) disable iff (!rstn)
        attr_we |=> attr_q == ($past(wsel.data) & bat_pkg::ATTR_WMASK);
    endproperty
    a_attr_write: assert property (p_attr_write)
        else $error("attribute register not loaded");

    property p_port_type;
        @(posedge clk) disable iff (!rstn)
        ##1 port_ttype == attr_q[bat_pkg::ATTR_TT_HI:bat_pkg::ATTR_TT_LO];
    endproperty
    a_port_type: assert property (p_port_type)
        else $error("port type out of step with register");

    property p_port_mod;
        @(posedge clk) disable iff (!rstn)
        ##1 port_tmod == attr_q[bat_pkg::ATTR_TM_HI:bat_pkg::ATTR_TM_LO];
    endproperty
    a_port_mod: assert property (p_port_mod)
        else $error("port modifier out of step with register");

    property p_unmasked_dir;
        @(posedge clk) disable iff (!rstn)
        (!attr_q[bat_pkg::ATTR_DIR_MASK] &&
            bus.dir != attr_q[bat_pkg::ATTR_DIR]) |=> !attr_match;
    endproperty
    a_unmasked_dir: assert property (p_unmasked_dir)
        else $error("direction mismatch still matched");

    property p_all_masked;
        @(posedge clk) disable iff (!rstn)
        (bus.valid &&
            attr_q[bat_pkg::ATTR_DIR_MASK:bat_pkg::ATTR_TM_MASK_LO] == 8'hff)
        |=> attr_match;
    endproperty
    a_all_masked: assert property (p_all_masked)
        else $error("fully masked compare failed");

    property p_lanes_off;
        @(posedge clk) disable iff (!rstn)
        !lanes_on |=> !data_match;
    endproperty
    a_lanes_off: assert property (p_lanes_off)
        else $error("data match with all lanes off");

    // ==========================================================
    // field views and write steps used by the checks below
    wire [7:0] mask_f =
        attr_q[bat_pkg::ATTR_DIR_MASK:bat_pkg::ATTR_TM_MASK_LO];
    wire [7:0] match_f = attr_q[bat_pkg::ATTR_DIR:bat_pkg::ATTR_TM_LO];
    wire [7:0] bus_f = {bus.dir, bus.size, bus.ttype, bus.tmod};
    wire [1:0] wr_ttype = wsel.data[bat_pkg::ATTR_TT_HI:bat_pkg::ATTR_TT_LO];
    wire [2:0] wr_tmod = wsel.data[bat_pkg::ATTR_TM_HI:bat_pkg::ATTR_TM_LO];
    wire [1:0] size_f =
        attr_q[bat_pkg::ATTR_SIZE_HI:bat_pkg::ATTR_SIZE_LO];
    wire [1:0] size_m =
        attr_q[bat_pkg::ATTR_SIZE_MASK_HI:bat_pkg::ATTR_SIZE_MASK_LO];
    wire [2:0] tm_f = attr_q[bat_pkg::ATTR_TM_HI:bat_pkg::ATTR_TM_LO];
    wire [2:0] tm_m =
        attr_q[bat_pkg::ATTR_TM_MASK_HI:bat_pkg::ATTR_TM_MASK_LO];

    sequence s_port_to(logic [3:0] r);
        port_wr.wr && port_wr.regno == r;
    endsequence

    // instruction write only counts when the port is quiet
    sequence s_instr_to(logic [3:0] r);
        instr_wr.wr && !port_wr.wr && instr_wr.regno == r;
    endsequence

    sequence s_fire_code(logic [1:0] code);
        fire && resp == code;
    endsequence

    property p_port_attr;
        @(posedge clk) disable iff (!rstn)
        s_port_to(bat_pkg::REG_ATTR) |=>
            attr_q == ($past(port_wr.data) & bat_pkg::ATTR_WMASK);
    endproperty
    a_port_attr: assert property (p_port_attr)
        else $error("port write to attribute register lost");

    property p_instr_attr;
        @(posedge clk) disable iff (!rstn)
        s_instr_to(bat_pkg::REG_ATTR) |=>
            attr_q == ($past(instr_wr.data) & bat_pkg::ATTR_WMASK);
    endproperty
    a_instr_attr: assert property (p_instr_attr)
        else $error("instruction write to attribute register lost");

    property p_port_tdef;
        @(posedge clk) disable iff (!rstn)
        s_port_to(bat_pkg::REG_TDEF) |=> tdef_q == $past(port_wr.data);
    endproperty
    a_port_tdef: assert property (p_port_tdef)
        else $error("port write to definition register lost");

    property p_instr_tdef;
        @(posedge clk) disable iff (!rstn)
        s_instr_to(bat_pkg::REG_TDEF) |=> tdef_q == $past(instr_wr.data);
    endproperty
    a_instr_tdef: assert property (p_instr_tdef)
        else $error("instruction write to definition register lost");

    property p_no_clear;
        @(posedge clk) disable iff (!rstn)
        !tdef_we |=> !status_clear;
    endproperty
    a_no_clear: assert property (p_no_clear)
        else $error("status cleared without definition write");

    property p_invalid_bus;
        @(posedge clk) disable iff (!rstn)
        !bus.valid |=> !attr_match;
    endproperty
    a_invalid_bus: assert property (p_invalid_bus)
        else $error("attribute match on idle bus");

    property p_show_only;
        @(posedge clk) disable iff (!rstn)
        s_fire_code(bat_pkg::RESP_SHOW) |=>
            show_status && !halt_req && !debug_irq;
    endproperty
    a_show_only: assert property (p_show_only)
        else $error("show response did more than show");

    property p_exact_match;
        @(posedge clk) disable iff (!rstn)
        (bus.valid && mask_f == 8'h00 && bus_f == match_f) |=> attr_match;
    endproperty
    a_exact_match: assert property (p_exact_match)
        else $error("equal unmasked attributes not matched");

    property p_size_miss;
        @(posedge clk) disable iff (!rstn)
        (size_m == 2'h0 && bus.size != size_f) |=> !attr_match;
    endproperty
    a_size_miss: assert property (p_size_miss)
        else $error("size mismatch still matched");

    property p_tm_miss;
        @(posedge clk) disable iff (!rstn)
        (tm_m == 3'h0 && bus.tmod != tm_f) |=> !attr_match;
    endproperty
    a_tm_miss: assert property (p_tm_miss)
        else $error("modifier mismatch still matched");

    property p_lane_gate;
        @(posedge clk) disable iff (!rstn)
        (l2_on && lanes_on && !(|(lane_en & lane_hit))) |=> !level2_fire;
    endproperty
    a_lane_gate: assert property (p_lane_gate)
        else $error("fire without an enabled lane hit");

    property p_reset_state;
        @(posedge clk)
        !rstn |=> port_tmod == tmod_rst && !level2_fire && !status_clear &&
            level_mode == bat_pkg::BAT_LVL_OFF;
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("outputs not at reset values");

    property p_type_write;
        @(posedge clk) disable iff (!rstn)
        attr_we |=> port_ttype == $past(wr_ttype);
    endproperty
    a_type_write: assert property (p_type_write)
        else $error("port type not taken from write");

    property p_mod_write;
        @(posedge clk) disable iff (!rstn)
        attr_we |=> port_tmod == $past(wr_tmod);
    endproperty
    a_mod_write: assert property (p_mod_write)
        else $error("port modifier not taken from write");

endmodule

// file: tb.sv
// testbench for the breakpoint attribute/trigger block.
// assumes bat_pkg and the bus partner model are compiled first.
`timescale 1ns/1ps

module tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    bat_pkg::bat_wr_s iw = '0;
    bat_pkg::bat_wr_s pw = '0;
    bat_pkg::bat_bus_s bus;
    logic [6:0] hits;
    logic addr_hit = 1'b0;
    logic attr_match, data_match, level2_fire, show_status;
    logic halt_req, debug_irq, status_clear, level1_enable;
    logic [1:0] port_ttype;
    logic [2:0] port_tmod;
    bat_pkg::bat_level_e level_mode;
    int error_cnt = 0;
    int tests_run = 0;
    logic [2:0] tm_codes [4] = '{3'h1, 3'h2, 3'h5, 3'h6};

    always #20 clk = ~clk;

    bat_bus_model u_bus (.bus(bus), .hits(hits));

    bat_trigger u_dut (.clk(clk), .rstn(rstn), .instr_wr(iw),
        .port_wr(pw), .bus(bus), .addr_hit(addr_hit),
        .data_hit_long(hits[6]), .data_hit_lword(hits[5]),
        .data_hit_uword(hits[4]),
        .data_hit_byte({hits[0], hits[1], hits[2], hits[3]}),
        .attr_match(attr_match), .data_match(data_match),
        .level2_fire(level2_fire), .show_status(show_status),
        .halt_req(halt_req), .debug_irq(debug_irq),
        .status_clear(status_clear), .port_ttype(port_ttype),
        .port_tmod(port_tmod), .level1_enable(level1_enable),
        .level_mode(level_mode));

    // ==========================================================
    // shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic port, input logic [3:0] r,
                      input logic [31:0] d);
        @(posedge clk);
        if (port) pw <= '{1'b1, r, d};
        else iw <= '{1'b1, r, d};
        @(posedge clk);
        pw.wr <= 1'b0;
        iw.wr <= 1'b0;
        #1;
    endtask

    task automatic probe(input logic [7:0] a, input logic ah,
                         input logic [6:0] h);
        @(posedge clk);
        u_bus.drive(1'b1, a, h);
        addr_hit <= ah;
        @(posedge clk);
        // release after the sampled cycle so no stale transfer lingers
        u_bus.drive(1'b0, 8'h00, 7'h00);
        #1;
    endtask

    // unmasked attribute bits must all agree
    function automatic logic am(input logic [15:0] r, input logic [7:0] a);
        return ((r[7:0] ^ a) & ~r[15:8]) == 8'h00;
    endfunction

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ==========================================================
    // scenarios
    task automatic t_reset();
        check(port_tmod, 3'h5);
        check(level_mode, bat_pkg::BAT_LVL_OFF);
        check({halt_req, debug_irq, level2_fire}, 3'h0);
    endtask

    task automatic t_attr();
        logic [15:0] r;
        for (int k = 0; k < 8; k++) begin
            r = 16'h0100 << k;
            wr(k[0], bat_pkg::REG_ATTR, {16'h0, r});
            probe(8'h01 << k, 1'b0, 7'h00);
            check(attr_match, am(r, 8'h01 << k));
            wr(~k[0], bat_pkg::REG_ATTR, 32'h0);
            check(status_clear, 1'b0);
            probe(8'h01 << k, 1'b0, 7'h00);
            check(attr_match, am(16'h0, 8'h01 << k));
        end
        for (int i = 0; i < 4; i++) begin
            wr(1'b1, bat_pkg::REG_ATTR, {24'h0, 3'h0, 2'h0, tm_codes[i]});
            check({port_ttype, port_tmod}, {2'h0, tm_codes[i]});
            probe({5'h0, tm_codes[i]}, 1'b0, 7'h00);
            check(attr_match, 1'b1);
        end
        wr(1'b0, bat_pkg::REG_ATTR, 32'h0000_ff00);
        probe(8'h00, 1'b0, 7'h00);
        check(attr_match, 1'b1);
        @(posedge clk);
        #1;
        check(attr_match, 1'b0);
    endtask

    task automatic t_prio();
        @(posedge clk);
        pw <= '{1'b1, bat_pkg::REG_ATTR, 32'h0};
        iw <= '{1'b1, bat_pkg::REG_ATTR, 32'h7};
        @(posedge clk);
        pw.wr <= 1'b0;
        iw.wr <= 1'b0;
        #1;
        check(port_tmod, 3'h0);
    endtask

    task automatic t_tdef();
        wr(1'b0, bat_pkg::REG_TDEF, 32'h0);
        wr(1'b0, bat_pkg::REG_ATTR, 32'hff00);
        for (int rs = 0; rs < 3; rs++) begin
            wr(rs[0], bat_pkg::REG_TDEF, {rs[1:0], 30'h2000_0000});
            check(status_clear, 1'b1);
            probe(8'h00, 1'b1, 7'h00);
            check({level2_fire, show_status}, 2'h3);
            check({halt_req, debug_irq}, {rs == 1, rs == 2});
            check(level_mode, bat_pkg::BAT_LVL_ONE);
            probe(8'h00, 1'b0, 7'h00);
            check(level2_fire, 1'b0);
        end
        wr(1'b1, bat_pkg::REG_TDEF, 32'h4000_0000);
        probe(8'h00, 1'b1, 7'h00);
        check({level2_fire, halt_req}, 2'h0);
        check(level_mode, bat_pkg::BAT_LVL_OFF);
        wr(1'b1, bat_pkg::REG_TDEF, 32'h2000_2000);
        probe(8'h00, 1'b0, 7'h00);
        check({level1_enable, level_mode}, {1'b1, bat_pkg::BAT_LVL_TWO});
        for (int j = 0; j < 7; j++) begin
            wr(1'b0, bat_pkg::REG_TDEF, 32'h2000_0000 | (32'h1 << (22 + j)));
            probe(8'h00, 1'b1, 7'h01 << j);
            check({data_match, level2_fire}, 2'h3);
            probe(8'h00, 1'b1, ~(7'h01 << j));
            check({data_match, level2_fire}, 2'h0);
        end
    endtask

    // ==========================================================
    // main sequence and watchdog
    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        #1;
        t_reset();
        t_attr();
        t_prio();
        t_tdef();
        print_verdict();
    end

    initial begin
        #100000;
        error_cnt++;
        print_verdict();
    end
endmodule
